// file: crbt_timer.sv
// Capture/reload/baud timer top level
`timescale 1ns/1ps
module crbt_timer
  import crbt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Timer inputs
  input wire logic speed_select,
  input wire logic timer_tick,
  input wire logic count_input_pin,
  input wire logic external_trigger_pin,
  input wire logic timer_irq_enable,
  // Serial port zero timebase
  input wire logic timer1_overflow,
  input wire logic serial_mode_13,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  // Interrupt request
  output logic timer_irq
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] ctrl_ff;
  logic [7:0] capl_ff;
  logic [7:0] caph_ff;
  logic [7:0] cntl_ff;
  logic [7:0] cnth_ff;
  logic div_ff;
  logic ovf_ff;
  logic count_fall;
  logic trig_fall;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  wire wr_ctrl = reg_wr & hit(reg_addr, CRBT_ADDR_CTRL);
  wire wr_capl = reg_wr & hit(reg_addr, CRBT_ADDR_CAPL);
  wire wr_caph = reg_wr & hit(reg_addr, CRBT_ADDR_CAPH);
  wire wr_cntl = reg_wr & hit(reg_addr, CRBT_ADDR_CNTL);
  wire wr_cnth = reg_wr & hit(reg_addr, CRBT_ADDR_CNTH);

  // ****************************************
  // Mode decode
  // ****************************************
  wire rx_sel = ctrl_ff[CRBT_BIT_RXSEL];
  wire tx_sel = ctrl_ff[CRBT_BIT_TXSEL];
  wire baud_mode = rx_sel | tx_sel;
  wire exen = ctrl_ff[CRBT_BIT_EXEN] & ~baud_mode;
  wire run = ctrl_ff[CRBT_BIT_RUN];
  wire capture_mode = ctrl_ff[CRBT_BIT_CPRL] & ~baud_mode;

  // Count enable source
  wire tick_src = ctrl_ff[CRBT_BIT_CT] ? count_fall : (speed_select | timer_tick);
  wire advance = run & (baud_mode ? div_ff : tick_src);

  wire [15:0] count = {cnth_ff, cntl_ff};
  wire [15:0] reload_val = {caph_ff, capl_ff};
  wire rollover = advance & (count == CRBT_CNT_MAX);
  wire trig_act = exen & trig_fall;
  wire do_capture = trig_act & capture_mode;
  wire do_reload = rollover & (~capture_mode | baud_mode)
                 | trig_act & ~capture_mode;
  wire [15:0] nxt_count = do_reload ? reload_val :
                          advance ? count + 16'h0001 : count;
  wire ovf_set = rollover & ~baud_mode;
  wire exf_set = trig_act;
  // Software-forced flags also request
  wire sw_force = wr_ctrl & (reg_wdata[CRBT_BIT_OVF] | reg_wdata[CRBT_BIT_EXF]);
  wire flag_req = ctrl_ff[CRBT_BIT_OVF] | ctrl_ff[CRBT_BIT_EXF] | sw_force;
  wire nxt_irq = timer_irq_enable & flag_req;
  wire nxt_rx = serial_mode_13 & (rx_sel ? ovf_ff : timer1_overflow);
  wire nxt_tx = serial_mode_13 & (tx_sel ? ovf_ff : timer1_overflow);

  logic [7:0] nxt_rdata;
  always_comb begin
    case (reg_addr)
      CRBT_ADDR_CTRL: nxt_rdata = ctrl_ff;
      CRBT_ADDR_CAPL: nxt_rdata = capl_ff;
      CRBT_ADDR_CAPH: nxt_rdata = caph_ff;
      CRBT_ADDR_CNTL: nxt_rdata = cntl_ff;
      CRBT_ADDR_CNTH: nxt_rdata = cnth_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // ****************************************
  // Submodules
  // ****************************************
  crbt_edge_sync u_cnt_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin(count_input_pin),
    .fall(count_fall)
  );

  crbt_edge_sync u_trig_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .pin(external_trigger_pin),
    .fall(trig_fall)
  );

  crbt_regs u_regs (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .wr_ctrl(wr_ctrl),
    .wdata(reg_wdata),
    .ovf_set(ovf_set),
    .exf_set(exf_set),
    .ctrl_ff(ctrl_ff)
  );

  // ****************************************
  // State
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cntl_ff <= CRBT_RST_BYTE;
      cnth_ff <= CRBT_RST_BYTE;
    end else if (clk_en) begin
      cntl_ff <= wr_cntl ? reg_wdata : nxt_count[7:0];
      cnth_ff <= wr_cnth ? reg_wdata : nxt_count[15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capl_ff <= CRBT_RST_BYTE;
      caph_ff <= CRBT_RST_BYTE;
    end else if (clk_en) begin
      if (do_capture) begin
        capl_ff <= cntl_ff;
        caph_ff <= cnth_ff;
      end else begin
        capl_ff <= wr_capl ? reg_wdata : capl_ff;
        caph_ff <= wr_caph ? reg_wdata : caph_ff;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 1'b0;
      ovf_ff <= 1'b0;
      timer_irq <= 1'b0;
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
      reg_rdata <= CRBT_RST_BYTE;
    end else if (clk_en) begin
      div_ff <= baud_mode & run & ~div_ff;
      ovf_ff <= rollover;
      timer_irq <= nxt_irq;
      rx_baud_tick <= nxt_rx;
      tx_baud_tick <= nxt_tx;
      reg_rdata <= nxt_rdata;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_ovf_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && rollover && !baud_mode && !wr_ctrl |=> ctrl_ff[CRBT_BIT_OVF])
    else $error("overflow flag not set");
  a_ovf_baud_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && baud_mode && !ctrl_ff[CRBT_BIT_OVF] && !wr_ctrl |=> !ctrl_ff[CRBT_BIT_OVF])
    else $error("overflow flag set in baud mode");
  a_sw_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && wr_ctrl && reg_wdata[CRBT_BIT_OVF] && timer_irq_enable |=> timer_irq)
    else $error("forced interrupt missing");
  a_exf_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && trig_act && !wr_ctrl |=> ctrl_ff[CRBT_BIT_EXF])
    else $error("edge flag not set");
  a_exf_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && wr_ctrl && reg_wdata[CRBT_BIT_EXF] && timer_irq_enable |=> timer_irq)
    else $error("edge flag interrupt missing");
  a_rx_source: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && serial_mode_13 && !rx_sel && timer1_overflow |=> rx_baud_tick)
    else $error("receive timebase wrong");
  a_halt_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !run && !trig_act && !wr_cntl && !wr_cnth |=> $stable(count))
    else $error("count moved while halted");
  a_baud_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && baud_mode && rollover && !wr_cntl && !wr_cnth |=> count == $past(reload_val))
    else $error("baud reload missing");
  a_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && do_capture |=> {caph_ff, capl_ff} == $past(count))
    else $error("capture missing");
  a_baud_half: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && advance && baud_mode |=> !advance || !baud_mode)
    else $error("baud mode too fast");

  // ****************************************
  // Checks: flags and interrupt
  // ****************************************
  a_ovf_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && ctrl_ff[CRBT_BIT_OVF] && !wr_ctrl |=> ctrl_ff[CRBT_BIT_OVF])
    else $error("overflow flag lost");
  a_ovf_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && wr_ctrl && !reg_wdata[CRBT_BIT_OVF] && !ovf_set |=> !ctrl_ff[CRBT_BIT_OVF])
    else $error("overflow flag not cleared");
  a_ovf_no_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !rollover && !wr_ctrl && !ctrl_ff[CRBT_BIT_OVF] |=> !ctrl_ff[CRBT_BIT_OVF])
    else $error("overflow flag set without rollover");
  a_exf_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && ctrl_ff[CRBT_BIT_EXF] && !wr_ctrl |=> ctrl_ff[CRBT_BIT_EXF])
    else $error("edge flag lost");
  a_exf_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && wr_ctrl && !reg_wdata[CRBT_BIT_EXF] && !exf_set |=> !ctrl_ff[CRBT_BIT_EXF])
    else $error("edge flag not cleared");
  a_exf_no_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !exen && !wr_ctrl && !ctrl_ff[CRBT_BIT_EXF] |=> !ctrl_ff[CRBT_BIT_EXF])
    else $error("edge flag set while ignored");
  a_irq_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !timer_irq_enable |=> !timer_irq)
    else $error("interrupt while disabled");
  a_irq_ovf: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && timer_irq_enable && ctrl_ff[CRBT_BIT_OVF] |=> timer_irq)
    else $error("overflow interrupt missing");
  a_irq_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && timer_irq_enable && ctrl_ff[CRBT_BIT_EXF] |=> timer_irq)
    else $error("edge interrupt missing");
  a_irq_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !ctrl_ff[CRBT_BIT_OVF] && !ctrl_ff[CRBT_BIT_EXF] && !wr_ctrl |=> !timer_irq)
    else $error("interrupt without flag");

  // ****************************************
  // Checks: serial timebase and baud mode
  // ****************************************
  a_tx_source: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && serial_mode_13 && !tx_sel && timer1_overflow |=> tx_baud_tick)
    else $error("transmit timebase wrong");
  a_rx_own: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && serial_mode_13 && rx_sel && ovf_ff |=> rx_baud_tick)
    else $error("receive tick from own overflow missing");
  a_tx_own: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && serial_mode_13 && tx_sel && ovf_ff |=> tx_baud_tick)
    else $error("transmit tick from own overflow missing");
  a_rx_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !serial_mode_13 |=> !rx_baud_tick)
    else $error("receive tick outside serial mode");
  a_tx_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !serial_mode_13 |=> !tx_baud_tick)
    else $error("transmit tick outside serial mode");
  a_baud_pace: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && baud_mode && run && !div_ff |=> div_ff)
    else $error("baud divider stalled");
  a_baud_no_trig: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && baud_mode && !advance && !wr_cntl && !wr_cnth |=> $stable(count))
    else $error("count moved by trigger in baud mode");
  a_baud_no_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && baud_mode && !wr_capl && !wr_caph |=> $stable(reload_val))
    else $error("capture in baud mode");

  // ****************************************
  // Checks: counting and reload
  // ****************************************
  wire cnt_free = clk_en & ~wr_cntl & ~wr_cnth & ~do_reload;
  wire pin_mode = run & ~baud_mode & ctrl_ff[CRBT_BIT_CT];
  wire tick_mode = run & ~baud_mode & ~ctrl_ff[CRBT_BIT_CT];
  a_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt_free && advance |=> count == $past(count) + 16'h0001)
    else $error("count did not step");
  a_pin_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt_free && pin_mode && count_fall |=> count == $past(count) + 16'h0001)
    else $error("pin edge not counted");
  a_pin_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt_free && pin_mode && !count_fall |=> $stable(count))
    else $error("count moved without pin edge");
  a_tick_fast: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt_free && tick_mode && speed_select |=> count == $past(count) + 16'h0001)
    else $error("fast tick not counted");
  a_tick_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt_free && tick_mode && !speed_select && !timer_tick |=> $stable(count))
    else $error("count moved without tick");
  a_reload_ovf: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && rollover && !capture_mode && !wr_cntl && !wr_cnth |=> count == $past(reload_val))
    else $error("overflow reload missing");
  a_reload_trig: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && trig_act && !capture_mode && !wr_cntl && !wr_cnth |=> count == $past(reload_val))
    else $error("trigger reload missing");
  a_cap_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt_free && rollover && capture_mode |=> count == 16'h0000)
    else $error("capture mode did not wrap");

  // ****************************************
  // Checks: capture, writes, pins and reads
  // ****************************************
  a_cap_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !do_capture && !wr_capl |=> $stable(capl_ff))
    else $error("capture low byte changed");
  a_caph_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !do_capture && !wr_caph |=> $stable(caph_ff))
    else $error("capture high byte changed");
  a_cap_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !exen && !wr_capl && !wr_caph |=> $stable(reload_val))
    else $error("capture while trigger ignored");
  a_cntl_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && wr_cntl |=> cntl_ff == $past(reg_wdata))
    else $error("count low write lost");
  a_cnth_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && wr_cnth |=> cnth_ff == $past(reg_wdata))
    else $error("count high write lost");
  a_cnt_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && count_fall |=> !count_fall)
    else $error("count pin edge repeated");
  a_trig_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && trig_fall |=> !trig_fall)
    else $error("trigger pin edge repeated");
  a_read_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_addr == CRBT_ADDR_CNTL |=> reg_rdata == $past(cntl_ff))
    else $error("count low read wrong");
  a_read_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_addr == CRBT_ADDR_CNTH |=> reg_rdata == $past(cnth_ff))
    else $error("count high read wrong");
  a_read_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && reg_addr == CRBT_ADDR_CAPL |=> reg_rdata == $past(capl_ff))
    else $error("capture low read wrong");
endmodule

// file: crbt_pkg.sv
// Package of constants for the capture/reload baud timer
package crbt_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] CRBT_ADDR_CTRL = 8'hC8;
  localparam logic [7:0] CRBT_ADDR_CAPL = 8'hCA;
  localparam logic [7:0] CRBT_ADDR_CAPH = 8'hCB;
  localparam logic [7:0] CRBT_ADDR_CNTL = 8'hCC;
  localparam logic [7:0] CRBT_ADDR_CNTH = 8'hCD;
  // ****************************************
  // Control field positions
  // ****************************************
  localparam int CRBT_BIT_OVF = 7;
  localparam int CRBT_BIT_EXF = 6;
  localparam int CRBT_BIT_RXSEL = 5;
  localparam int CRBT_BIT_TXSEL = 4;
  localparam int CRBT_BIT_EXEN = 3;
  localparam int CRBT_BIT_RUN = 2;
  localparam int CRBT_BIT_CT = 1;
  localparam int CRBT_BIT_CPRL = 0;
  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] CRBT_RST_BYTE = 8'h00;
  localparam logic [15:0] CRBT_CNT_MAX = 16'hFFFF;
  localparam int CRBT_BAUD_DIV = 2;
endpackage

// file: crbt_edge_sync.sv
// Pin synchroniser with falling edge pulse
`timescale 1ns/1ps
module crbt_edge_sync
  import crbt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Pin and event
  input wire logic pin,
  output logic fall
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  wire nxt_fall = s3_ff & ~s2_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else if (clk_en) begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // One-cycle pulse per edge
  assign fall = nxt_fall & clk_en;
endmodule

// file: crbt_regs.sv
// Control register with sticky flags
`timescale 1ns/1ps
module crbt_regs
  import crbt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Write port
  input wire logic wr_ctrl,
  input wire logic [7:0] wdata,
  // Hardware events
  input wire logic ovf_set,
  input wire logic exf_set,
  // State
  output logic [7:0] ctrl_ff
);
  wire [7:0] nxt_ctrl;
  wire [7:0] base = wr_ctrl ? wdata : ctrl_ff;

  // Hardware set wins over software clear
  assign nxt_ctrl = base | ({7'h00, ovf_set} << CRBT_BIT_OVF)
                         | ({7'h00, exf_set} << CRBT_BIT_EXF);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CRBT_RST_BYTE;
    end else if (clk_en) begin
      ctrl_ff <= nxt_ctrl;
    end
  end
endmodule

// file: crbt_pins.sv
// Model of the count pin, trigger pin and timer 1 overflow
`timescale 1ns/1ps
module crbt_pins (
  // Clock
  input wire logic ref_clk,
  // Pins, idle high by pull-up; timer 1 overflow idle low
  output logic count_pin,
  output logic trig_pin,
  output logic t1_ovf
);
  initial begin
    count_pin = 1'b1;
    trig_pin = 1'b1;
    t1_ovf = 1'b0;
  end
  // Falling edges, low held three clocks, high four between edges
  task automatic edges(input bit trig, input int n);
    repeat (n) begin
      @(posedge ref_clk) #1;
      if (trig) trig_pin = 1'b0; else count_pin = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      if (trig) trig_pin = 1'b1; else count_pin = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
    end
  endtask
  // One-cycle overflow pulses of timer 1
  task automatic t1(input int n);
    repeat (n) begin
      @(posedge ref_clk) #1 t1_ovf = 1'b1;
      @(posedge ref_clk) #1 t1_ovf = 1'b0;
      @(posedge ref_clk);
    end
  endtask
endmodule

// file: crbt_timer_test.sv
// Self-checking bench for the capture/reload baud timer
`timescale 1ns/1ps
module crbt_timer_test;
  import crbt_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, rd_req = 1'b0, rd_q = 1'b0;
  logic speed_select = 1'b0, timer_tick = 1'b0, irq_en = 1'b1, ser13 = 1'b0, clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, lo, hi;
  logic cpin, tpin, t1o, rx_tick, tx_tick, timer_irq;
  logic [7:0] exp_q[$];
  logic [7:0] addrs[6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};
  int n_fail = 0, n_tests = 0, nrx, ntx;
  always #20 ref_clk = ~ref_clk;
  crbt_pins pins_u (.ref_clk(ref_clk), .count_pin(cpin), .trig_pin(tpin), .t1_ovf(t1o));
  crbt_timer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .speed_select(speed_select), .timer_tick(timer_tick), .count_input_pin(cpin),
    .external_trigger_pin(tpin), .timer_irq_enable(irq_en), .timer1_overflow(t1o),
    .serial_mode_13(ser13), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick),
    .timer_irq(timer_irq));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    rd_req = 1'b1;
    exp_q.push_back(e);
    tick(1);
    rd_req = 1'b0;
    tick(1);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      timer_tick = 1'b1;
      tick(1);
      timer_tick = 1'b0;
      tick(1);
    end
  endtask
  task automatic watch(input int n);
    nrx = 0;
    ntx = 0;
    repeat (n) begin
      @(negedge ref_clk);
      nrx += int'(rx_tick);
      ntx += int'(tx_tick);
    end
    tick(1);
  endtask
  // Read results against the oldest note
  always @(posedge ref_clk) rd_q <= rd_req;
  always @(negedge ref_clk) if (rd_q) check("reg_rdata", reg_rdata, exp_q.pop_front());
  initial begin
    #100000;
    n_fail++;
    conclude();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(55205));
    lo = 8'($urandom);
    hi = 8'($urandom);
    tick(20);
    rst_n = 1'b1;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    wr(8'hCA, lo);
    wr(8'hCB, hi);
    wr(8'hCC, 8'hFD);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    ticks(3);
    check("irq ovf", timer_irq, 8'h01);
    rd(8'hC8, 8'h84);
    rd(8'hCC, lo);
    rd(8'hCD, hi);
    wr(8'hC8, 8'h00);
    check("irq clr", timer_irq, 8'h00);
    ticks(2);
    rd(8'hCC, lo);
    wr(8'hC8, 8'h80);
    check("irq sw", timer_irq, 8'h01);
    irq_en = 1'b0;
    tick(1);
    check("irq off", timer_irq, 8'h00);
    irq_en = 1'b1;
    wr(8'hCC, 8'h10);
    wr(8'hCD, 8'h00);
    speed_select = 1'b1;
    wr(8'hC8, 8'h04);
    tick(4);
    clk_en = 1'b0;
    tick(3);
    clk_en = 1'b1;
    wr(8'hC8, 8'h00);
    speed_select = 1'b0;
    rd(8'hCC, 8'h16);
    rd(8'hCD, 8'h00);
    wr(8'hCC, 8'h00);
    wr(8'hCD, 8'h00);
    wr(8'hC8, 8'h06);
    pins_u.edges(1'b0, 5);
    ticks(2);
    wr(8'hC8, 8'h00);
    rd(8'hCC, 8'h05);
    wr(8'hC8, 8'h05);
    pins_u.edges(1'b1, 1);
    rd(8'hC8, 8'h05);
    rd(8'hCA, lo);
    wr(8'hC8, 8'h0D);
    pins_u.edges(1'b1, 1);
    check("irq edge", timer_irq, 8'h01);
    rd(8'hC8, 8'h4D);
    rd(8'hCA, 8'h05);
    rd(8'hCB, 8'h00);
    wr(8'hC8, 8'h00);
    wr(8'hC8, 8'h40);
    check("irq sw edge", timer_irq, 8'h01);
    wr(8'hCC, 8'hAA);
    wr(8'hCD, 8'hAA);
    wr(8'hC8, 8'h08);
    pins_u.edges(1'b1, 1);
    rd(8'hCC, 8'h05);
    rd(8'hCD, 8'h00);
    wr(8'hCA, 8'hFE);
    wr(8'hCB, 8'hFF);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    ser13 = 1'b1;
    wr(8'hC8, 8'h25);
    fork
      watch(40);
      pins_u.t1(6);
    join
    check("rx rate", 8'(nrx inside {[9:11]}), 8'h01);
    check("tx from t1", 8'(ntx), 8'h06);
    rd(8'hC8, 8'h25);
    wr(8'hC8, 8'h16);
    watch(40);
    check("tx rate", 8'(ntx inside {[9:11]}), 8'h01);
    check("rx from t1", 8'(nrx), 8'h00);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    rd(8'hC8, 8'h00);
    rd(8'hCD, 8'h00);
    tick(2);
    conclude();
  end
endmodule
